/* File: pkg/tcb_pkg.sv */
package tcb_pkg;
   // byte locations on the 8-bit i/o side
   localparam logic [3:0] TCB_LOC_CNT_LO  = 4'h0;
   localparam logic [3:0] TCB_LOC_CNT_HI  = 4'h1;
   localparam logic [3:0] TCB_LOC_CMPA_LO = 4'h2;
   localparam logic [3:0] TCB_LOC_CMPA_HI = 4'h3;
   localparam logic [3:0] TCB_LOC_CMPB_LO = 4'h4;
   localparam logic [3:0] TCB_LOC_CMPB_HI = 4'h5;
   localparam logic [3:0] TCB_LOC_CAPT_LO = 4'h6;
   localparam logic [3:0] TCB_LOC_CAPT_HI = 4'h7;
   localparam logic [3:0] TCB_LOC_CTRL_A  = 4'h8;
   localparam logic [3:0] TCB_LOC_CTRL_B  = 4'h9;
   localparam logic [3:0] TCB_LOC_FLAGS   = 4'hA;
   localparam int         TCB_LOC_W       = 4;
   // control field positions
   localparam int TCB_A_WGM_LSB  = 0;
   localparam int TCB_B_CS_LSB   = 0;
   localparam int TCB_B_WGM_LSB  = 3;
   localparam int TCB_FLAG_OVF   = 0;
   // count limits
   localparam logic [15:0] TCB_BOTTOM = 16'h0000;
   localparam logic [15:0] TCB_MAX    = 16'hFFFF;
   localparam logic [15:0] TCB_TOP8   = 16'h00FF;
   localparam logic [15:0] TCB_TOP9   = 16'h01FF;
   localparam logic [15:0] TCB_TOP10  = 16'h03FF;
   localparam logic [15:0] TCB_ONE    = 16'h0001;
   // tick source select codes
   localparam logic [2:0] TCB_CS_STOP  = 3'h0;
   localparam logic [2:0] TCB_CS_DIV1  = 3'h1;
   localparam logic [2:0] TCB_CS_DIV8  = 3'h2;
   localparam logic [2:0] TCB_CS_DIV64 = 3'h3;
   localparam logic [2:0] TCB_CS_DIV256  = 3'h4;
   localparam logic [2:0] TCB_CS_DIV1024 = 3'h5;
   localparam logic [2:0] TCB_CS_EXT_FALL = 3'h6;
   localparam logic [2:0] TCB_CS_EXT_RISE = 3'h7;
   localparam int          TCB_PRE_W      = 10;
   localparam logic [9:0]  TCB_PRE_M8     = 10'h007;
   localparam logic [9:0]  TCB_PRE_M64    = 10'h03F;
   localparam logic [9:0]  TCB_PRE_M256   = 10'h0FF;
   localparam logic [9:0]  TCB_PRE_M1024  = 10'h3FF;
   localparam logic [9:0]  TCB_PRE_ONE    = 10'h001;
   // controller registers on ahb-lite (byte addresses)
   localparam logic [7:0] TCB_AHB_DATA   = 8'h00;
   localparam logic [7:0] TCB_AHB_TARGET = 8'h04;
   localparam logic [7:0] TCB_AHB_CMD    = 8'h08;
   localparam logic [7:0] TCB_AHB_STATUS = 8'h0C;
   localparam logic [7:0] TCB_AHB_RDATA  = 8'h10;
   localparam int TCB_CMD_WR    = 0;
   localparam int TCB_CMD_RD    = 1;
   localparam int TCB_CMD_BYTE  = 2;
   localparam int TCB_CMD_KEEPH = 3;
   localparam logic [1:0] TCB_HTRANS_NONSEQ = 2'h2;
   localparam logic       TCB_HRESP_OKAY    = 1'b0;
endpackage : tcb_pkg

/* File: pkg/tcb_if.sv */
`timescale 1ns/1ps
interface tcb_if;
   logic [3:0] io_addr;
   logic       io_wr;
   logic       io_rd;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   modport dev (input io_addr, input io_wr, input io_rd, input io_wdata, output io_rdata);
   modport cpu (output io_addr, output io_wr, output io_rd, output io_wdata, input io_rdata);
endinterface : tcb_if

/* File: hw/tcb_tick_gen.sv */
`timescale 1ns/1ps
module tcb_tick_gen
   import tcb_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [2:0] tick_source_select,
   input  wire logic       ext_pin,
   output logic            timer_tick
);
   logic [TCB_PRE_W-1:0] pre_reg;
   logic                 pin_meta_reg;
   logic                 pin_sync_reg;
   logic                 pin_prev_reg;
   logic                 tick_next;

   // free-running prescaler, shared by all divided sources
   always_ff @(posedge clk) begin
      if (srst) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_reg + TCB_PRE_ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
      end else begin
         pin_meta_reg <= ext_pin;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   always_comb begin
      unique case (tick_source_select)
         TCB_CS_STOP:     tick_next = 1'b0;
         TCB_CS_DIV1:     tick_next = 1'b1;
         TCB_CS_DIV8:     tick_next = (pre_reg[2:0] == TCB_PRE_M8[2:0]);
         TCB_CS_DIV64:    tick_next = (pre_reg[5:0] == TCB_PRE_M64[5:0]);
         TCB_CS_DIV256:   tick_next = (pre_reg[7:0] == TCB_PRE_M256[7:0]);
         TCB_CS_DIV1024:  tick_next = (pre_reg == TCB_PRE_M1024);
         TCB_CS_EXT_FALL: tick_next = pin_prev_reg & ~pin_sync_reg;
         TCB_CS_EXT_RISE: tick_next = ~pin_prev_reg & pin_sync_reg;
      endcase
   end

   // registered so a tick never races a select change in the same cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         timer_tick <= 1'b0;
      end else begin
         timer_tick <= tick_next;
      end
   end
endmodule : tcb_tick_gen

/* File: hw/tcb_device.sv */
`timescale 1ns/1ps
// Summary of operation
// - 16-bit registers move as two byte accesses
// - one shared high-byte holding register
// - low-byte write loads held high byte too
// - count/capture low-byte read copies high byte to holder
// - compare reads bypass the holding register
// - cpu writes high first, reads low first
// - counter occupies two byte locations
// - counter high location reaches holding register
// - holding register keeps value between accesses
// - three-bit field picks tick source
// - select zero halts the counter
// - counter accessible with or without ticks
// - cpu write beats clear or count
// - tick clears, increments or decrements counter
// - clear forces all counter bits zero
// - top and bottom indications from counter
// - four-bit mode field split over a/b
// - overflow flag set where mode defines
// - bottom 0000, max ffff, top per mode
module tcb_device
   import tcb_pkg::*;
(
   input  wire logic clk,
   input  wire logic srst,
   tcb_if.dev        bus,
   input  wire logic ext_tick_pin,
   output logic      count_top,
   output logic      count_bottom,
   output logic      overflow_flag
);
   logic [15:0] count_value_reg;
   logic [15:0] compare_a_reg;
   logic [15:0] compare_b_reg;
   logic [15:0] capture_value_reg;
   logic [7:0]  hold_high_reg;
   logic [7:0]  control_reg_a;
   logic [7:0]  control_reg_b;
   logic [7:0]  rdata_reg;
   logic        down_reg;
   logic        timer_tick;
   logic [3:0]  waveform_mode_field;
   logic [15:0] top_value;
   logic        dual_slope;
   logic        ovf_at_top;
   logic        capt_is_top;
   logic        wr_lo;
   logic        rd_lo;
   logic        wr_hi;
   logic        ovf_event;
   logic [15:0] wr_word;

   assign waveform_mode_field = {control_reg_b[TCB_B_WGM_LSB+1 -: 2],
                                 control_reg_a[TCB_A_WGM_LSB+1 -: 2]};
   // low and high locations differ only in bit 0, for the four 16-bit registers
   assign wr_lo   = bus.io_wr & ~bus.io_addr[0] & (bus.io_addr < TCB_LOC_CTRL_A);
   assign wr_hi   = bus.io_wr &  bus.io_addr[0] & (bus.io_addr < TCB_LOC_CTRL_A);
   assign rd_lo   = bus.io_rd & ~bus.io_addr[0] & (bus.io_addr < TCB_LOC_CTRL_A);
   assign wr_word = {hold_high_reg, bus.io_wdata};

   tcb_tick_gen tcb_tick_gen_i (
      .clk                (clk),
      .srst               (srst),
      .tick_source_select (control_reg_b[TCB_B_CS_LSB+2 -: 3]),
      .ext_pin            (ext_tick_pin),
      .timer_tick         (timer_tick)
   );

   always_comb begin
      dual_slope  = 1'b0;
      ovf_at_top  = 1'b0;
      capt_is_top = 1'b0;
      unique case (waveform_mode_field)
         4'h1, 4'h2, 4'h3: begin
            dual_slope = 1'b1;
            top_value  = (waveform_mode_field == 4'h1) ? TCB_TOP8 :
                         (waveform_mode_field == 4'h2) ? TCB_TOP9 : TCB_TOP10;
         end
         4'h5: begin
            top_value  = TCB_TOP8;
            ovf_at_top = 1'b1;
         end
         4'h6: begin
            top_value  = TCB_TOP9;
            ovf_at_top = 1'b1;
         end
         4'h7: begin
            top_value  = TCB_TOP10;
            ovf_at_top = 1'b1;
         end
         4'h4: top_value = compare_a_reg;
         4'h9, 4'hB: begin
            dual_slope = 1'b1;
            top_value  = compare_a_reg;
         end
         4'h8, 4'hA: begin
            dual_slope  = 1'b1;
            capt_is_top = 1'b1;
            top_value   = capture_value_reg;
         end
         4'hC: begin
            capt_is_top = 1'b1;
            top_value   = capture_value_reg;
         end
         4'hE: begin
            capt_is_top = 1'b1;
            ovf_at_top  = 1'b1;
            top_value   = capture_value_reg;
         end
         4'hF: begin
            ovf_at_top = 1'b1;
            top_value  = compare_a_reg;
         end
         // mode 0 and the reserved code count the full range
         default: top_value = TCB_MAX;
      endcase
   end

   // the counter and its direction
   always_ff @(posedge clk) begin
      if (srst) begin
         count_value_reg <= TCB_BOTTOM;
         down_reg        <= 1'b0;
      end else if (wr_lo && bus.io_addr == TCB_LOC_CNT_LO) begin
         count_value_reg <= wr_word;
      end else if (timer_tick) begin
         if (!dual_slope) begin
            if (count_value_reg == top_value) begin
               count_value_reg <= TCB_BOTTOM;
            end else begin
               count_value_reg <= count_value_reg + TCB_ONE;
            end
         end else if (!down_reg) begin
            if (count_value_reg >= top_value) begin
               down_reg        <= 1'b1;
               count_value_reg <= count_value_reg - TCB_ONE;
            end else begin
               count_value_reg <= count_value_reg + TCB_ONE;
            end
         end else if (count_value_reg == TCB_BOTTOM) begin
            down_reg        <= 1'b0;
            count_value_reg <= count_value_reg + TCB_ONE;
         end else begin
            count_value_reg <= count_value_reg - TCB_ONE;
         end
      end
   end

   // overflow: at top in fast pwm, at bottom in dual slope, at max otherwise
   assign ovf_event = timer_tick & (dual_slope ? (down_reg && count_value_reg == TCB_BOTTOM) :
                      ovf_at_top ? (count_value_reg == top_value) :
                      (count_value_reg == TCB_MAX));

   always_ff @(posedge clk) begin
      if (srst) begin
         overflow_flag <= 1'b0;
      end else if (ovf_event) begin
         overflow_flag <= 1'b1;
      end else if (bus.io_wr && bus.io_addr == TCB_LOC_FLAGS && bus.io_wdata[TCB_FLAG_OVF]) begin
         overflow_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         count_top    <= 1'b0;
         count_bottom <= 1'b1;
      end else begin
         count_top    <= (count_value_reg == top_value);
         count_bottom <= (count_value_reg == TCB_BOTTOM);
      end
   end

   // one holding register serves every 16-bit register on writes, and count and capture on reads
   always_ff @(posedge clk) begin
      if (srst) begin
         hold_high_reg <= '0;
      end else if (wr_hi) begin
         hold_high_reg <= bus.io_wdata;
      end else if (rd_lo && bus.io_addr == TCB_LOC_CNT_LO) begin
         hold_high_reg <= count_value_reg[15:8];
      end else if (rd_lo && bus.io_addr == TCB_LOC_CAPT_LO) begin
         hold_high_reg <= capture_value_reg[15:8];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         compare_a_reg     <= '0;
         compare_b_reg     <= '0;
         capture_value_reg <= '0;
      end else if (wr_lo) begin
         if (bus.io_addr == TCB_LOC_CMPA_LO) begin
            compare_a_reg <= wr_word;
         end
         if (bus.io_addr == TCB_LOC_CMPB_LO) begin
            compare_b_reg <= wr_word;
         end
         // capture value is writable only while it defines top
         if (bus.io_addr == TCB_LOC_CAPT_LO && capt_is_top) begin
            capture_value_reg <= wr_word;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         control_reg_a <= '0;
         control_reg_b <= '0;
      end else if (bus.io_wr && bus.io_addr == TCB_LOC_CTRL_A) begin
         control_reg_a <= bus.io_wdata;
      end else if (bus.io_wr && bus.io_addr == TCB_LOC_CTRL_B) begin
         control_reg_b <= bus.io_wdata;
      end
   end

   // read data lands one cycle after the strobe
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_reg <= '0;
      end else if (bus.io_rd) begin
         unique case (bus.io_addr)
            TCB_LOC_CNT_LO:  rdata_reg <= count_value_reg[7:0];
            TCB_LOC_CNT_HI:  rdata_reg <= hold_high_reg;
            TCB_LOC_CMPA_LO: rdata_reg <= compare_a_reg[7:0];
            TCB_LOC_CMPA_HI: rdata_reg <= compare_a_reg[15:8];
            TCB_LOC_CMPB_LO: rdata_reg <= compare_b_reg[7:0];
            TCB_LOC_CMPB_HI: rdata_reg <= compare_b_reg[15:8];
            TCB_LOC_CAPT_LO: rdata_reg <= capture_value_reg[7:0];
            TCB_LOC_CAPT_HI: rdata_reg <= hold_high_reg;
            TCB_LOC_CTRL_A:  rdata_reg <= control_reg_a;
            TCB_LOC_CTRL_B:  rdata_reg <= control_reg_b;
            TCB_LOC_FLAGS:   rdata_reg <= {7'h00, overflow_flag};
            default:         rdata_reg <= '0;
         endcase
      end
   end

   assign bus.io_rdata = rdata_reg;
endmodule : tcb_device

/* File: hw/tcb_cpu_end.sv */
`timescale 1ns/1ps
module tcb_cpu_end
   import tcb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   tcb_if.cpu               bus
);
   typedef enum logic [4:0] {
      TCB_S_IDLE  = 5'b00001,
      TCB_S_FIRST = 5'b00010,
      TCB_S_GAP   = 5'b00100,
      TCB_S_LAST  = 5'b01000,
      TCB_S_DONE  = 5'b10000
   } tcb_state_e;

   tcb_state_e  state_reg;
   logic [15:0] data_reg;
   logic [3:0]  target_reg;
   logic [3:0]  cmd_reg;
   logic [15:0] rdata_reg;
   logic        ap_wr_reg;
   logic [7:0]  ap_addr_reg;
   logic        ap_take;
   logic        busy;
   logic [3:0]  lo_loc;

   assign ap_take = hsel & hready & (htrans == TCB_HTRANS_NONSEQ);
   assign busy    = (state_reg != TCB_S_IDLE);
   assign lo_loc  = {target_reg[3:1], 1'b0};
   // hsize is always a word here; sub-word accesses act as words
   logic unused_hsize;
   assign unused_hsize = |hsize;

   always_ff @(posedge clk) begin
      if (srst) begin
         ap_wr_reg   <= 1'b0;
         ap_addr_reg <= '0;
         hreadyout   <= 1'b1;
         hresp       <= TCB_HRESP_OKAY;
         hrdata      <= '0;
      end else begin
         ap_wr_reg   <= ap_take & hwrite;
         ap_addr_reg <= haddr[7:0];
         if (ap_take && !hwrite) begin
            unique case (haddr[7:0])
               TCB_AHB_DATA:   hrdata <= {16'h0000, data_reg};
               TCB_AHB_TARGET: hrdata <= {28'h0000000, target_reg};
               TCB_AHB_CMD:    hrdata <= {28'h0000000, cmd_reg};
               TCB_AHB_STATUS: hrdata <= {31'h00000000, busy};
               TCB_AHB_RDATA:  hrdata <= {16'h0000, rdata_reg};
               default:        hrdata <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         data_reg   <= '0;
         target_reg <= '0;
      end else if (ap_wr_reg && !busy) begin
         if (ap_addr_reg == TCB_AHB_DATA) begin
            data_reg <= hwdata[15:0];
         end
         if (ap_addr_reg == TCB_AHB_TARGET) begin
            target_reg <= hwdata[3:0];
         end
      end
   end

   // high byte first on write, low byte first on read
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg    <= TCB_S_IDLE;
         cmd_reg      <= '0;
         rdata_reg    <= '0;
         bus.io_addr  <= '0;
         bus.io_wr    <= 1'b0;
         bus.io_rd    <= 1'b0;
         bus.io_wdata <= '0;
      end else begin
         bus.io_wr <= 1'b0;
         bus.io_rd <= 1'b0;
         unique case (state_reg)
            TCB_S_IDLE: begin
               if (ap_wr_reg && ap_addr_reg == TCB_AHB_CMD) begin
                  cmd_reg   <= hwdata[3:0];
                  state_reg <= TCB_S_FIRST;
               end
            end
            TCB_S_FIRST: begin
               if (cmd_reg[TCB_CMD_BYTE]) begin
                  bus.io_addr  <= target_reg;
                  bus.io_wdata <= data_reg[7:0];
                  bus.io_wr    <= cmd_reg[TCB_CMD_WR];
                  bus.io_rd    <= cmd_reg[TCB_CMD_RD];
                  state_reg    <= cmd_reg[TCB_CMD_WR] ? TCB_S_DONE : TCB_S_LAST;
               end else if (cmd_reg[TCB_CMD_WR]) begin
                  // keep-high reuses the holding register's present value
                  bus.io_addr  <= lo_loc | 4'h1;
                  bus.io_wdata <= data_reg[15:8];
                  bus.io_wr    <= ~cmd_reg[TCB_CMD_KEEPH];
                  state_reg    <= TCB_S_LAST;
               end else begin
                  bus.io_addr <= lo_loc;
                  bus.io_rd   <= 1'b1;
                  state_reg   <= TCB_S_GAP;
               end
            end
            TCB_S_GAP: begin
               bus.io_addr <= lo_loc | 4'h1;
               bus.io_rd   <= 1'b1;
               state_reg   <= TCB_S_LAST;
            end
            TCB_S_LAST: begin
               if (cmd_reg[TCB_CMD_WR]) begin
                  bus.io_addr  <= lo_loc;
                  bus.io_wdata <= data_reg[7:0];
                  bus.io_wr    <= 1'b1;
               end else begin
                  rdata_reg[7:0] <= bus.io_rdata;
               end
               state_reg <= TCB_S_DONE;
            end
            TCB_S_DONE: begin
               if (cmd_reg[TCB_CMD_RD] && cmd_reg[TCB_CMD_BYTE]) begin
                  rdata_reg <= {8'h00, bus.io_rdata};
               end else if (cmd_reg[TCB_CMD_RD]) begin
                  rdata_reg[15:8] <= bus.io_rdata;
               end
               state_reg <= TCB_S_IDLE;
            end
         endcase
      end
   end
endmodule : tcb_cpu_end

/* File: dv/tcb_monitor.sv */
`timescale 1ns/1ps
module tcb_monitor
   import tcb_pkg::*;
(
   input wire logic       clk,
   input wire logic       srst,
   input wire logic [3:0] io_addr,
   input wire logic       io_wr,
   input wire logic       io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata
);
   logic [7:0]  hold_reg;
   logic        hok_reg;
   logic [15:0] cnt_reg;
   logic        cok_reg;
   logic [4:0]  ctlb_reg;
   logic [7:0]  cnt_lo;
   wire         hi_wr = io_wr && io_addr[0] && (io_addr < TCB_LOC_CTRL_A);
   wire         stop = ctlb_reg[2:0] == TCB_CS_STOP;
   assign cnt_lo = cnt_reg[7:0];
   default clocking cb @(posedge clk); endclocking
   // capture value is not modelled, so its low read leaves the holder unknown
   always_ff @(posedge clk) begin
      if (srst) begin
         hold_reg <= 8'h00;
         hok_reg <= 1'b1;
      end else if (hi_wr) begin
         hold_reg <= io_wdata;
         hok_reg <= 1'b1;
      end else if (io_rd && io_addr == TCB_LOC_CNT_LO) begin
         hold_reg <= cnt_reg[15:8];
         hok_reg <= cok_reg && stop;
      end else if (io_rd && io_addr == TCB_LOC_CAPT_LO) begin
         hok_reg <= 1'b0;
      end
   end
   // count is only predictable while no tick source runs
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_reg <= 16'h0000;
         cok_reg <= 1'b1;
      end else if (io_wr && io_addr == TCB_LOC_CNT_LO) begin
         cnt_reg <= {hold_reg, io_wdata};
         cok_reg <= hok_reg;
      end else if (!stop) begin
         cok_reg <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         ctlb_reg <= 5'h00;
      end else if (io_wr && io_addr == TCB_LOC_CTRL_B) begin
         ctlb_reg <= io_wdata[4:0];
      end
   end
   property p_one_strobe; disable iff (srst) !(io_wr && io_rd); endproperty
   a_one_strobe: assert property (p_one_strobe) else $error("two strobes");
   property p_rst_quiet; srst |=> !io_wr && !io_rd && io_rdata == 8'h00; endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("link busy in reset");
   property p_cnt_hi;
      disable iff (srst) io_rd && io_addr == TCB_LOC_CNT_HI && hok_reg |=>
         io_rdata == $past(hold_reg);
   endproperty
   a_cnt_hi: assert property (p_cnt_hi) else $error("count high not holder");
   property p_capt_hi;
      disable iff (srst) io_rd && io_addr == TCB_LOC_CAPT_HI && hok_reg |=>
         io_rdata == $past(hold_reg);
   endproperty
   a_capt_hi: assert property (p_capt_hi) else $error("capture high not holder");
   property p_cnt_lo;
      disable iff (srst) io_rd && io_addr == TCB_LOC_CNT_LO && cok_reg && stop |=>
         io_rdata == $past(cnt_lo);
   endproperty
   a_cnt_lo: assert property (p_cnt_lo) else $error("count low wrong");
   property p_stands; disable iff (srst) !io_rd |=> $stable(io_rdata); endproperty
   a_stands: assert property (p_stands) else $error("read byte moved");
   property p_unmapped;
      disable iff (srst) io_rd && io_addr > TCB_LOC_FLAGS |=> io_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
   property p_ctlb;
      disable iff (srst) io_rd && io_addr == TCB_LOC_CTRL_B |=> io_rdata[4:0] == $past(ctlb_reg);
   endproperty
   a_ctlb: assert property (p_ctlb) else $error("control b readback");
endmodule : tcb_monitor

/* File: dv/tcb_bench.sv */
`timescale 1ns/1ps
module tcb_bench
   import tcb_pkg::*;
;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [3:0]  ext_cnt = 4'h0;
   logic        hreadyout, hresp, count_top, count_bottom, overflow_flag;
   logic [15:0] q;
   int          top_n = 0;
   int          bot_n = 0;
   int          fails = 0;
   int          total_checks = 0;
   localparam logic [3:0] WR = 4'h1;
   localparam logic [3:0] RD = 4'h2;
   localparam logic [3:0] BW = 4'h5;
   localparam logic [3:0] BR = 4'h6;
   localparam logic [3:0] KW = 4'h9;
   tcb_if bus_if ();
   tcb_device tcb_device_i (.clk(clk), .srst(srst), .bus(bus_if), .ext_tick_pin(ext_cnt[3]),
      .count_top(count_top), .count_bottom(count_bottom), .overflow_flag(overflow_flag));
   tcb_cpu_end tcb_cpu_end_i (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus(bus_if));
   tcb_monitor tcb_monitor_i (.clk(clk), .srst(srst), .io_addr(bus_if.io_addr),
      .io_wr(bus_if.io_wr), .io_rd(bus_if.io_rd), .io_wdata(bus_if.io_wdata),
      .io_rdata(bus_if.io_rdata));
   initial begin
      forever #4 clk = ~clk;
   end
   // external pin toggles every 8 cycles, slow enough for the edge sampler
   always @(posedge clk) begin
      ext_cnt <= ext_cnt + 4'h1;
      top_n <= top_n + (count_top === 1'b1);
      bot_n <= bot_n + (count_bottom === 1'b1);
   end
   task automatic tally_and_finish();
      if (fails == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_in(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      total_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         fails++;
         $display("MISMATCH %0t got %h outside %h..%h", $time, got, lo, hi);
      end
   endtask : chk_in
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= TCB_HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic dev(input logic [3:0] cmd, input logic [3:0] loc, input logic [15:0] d,
                      output logic [15:0] r);
      logic [31:0] w;
      int          n;
      ahb(1'b1, TCB_AHB_DATA, {16'h0, d}, w);
      ahb(1'b1, TCB_AHB_TARGET, {28'h0, loc}, w);
      ahb(1'b1, TCB_AHB_CMD, {28'h0, cmd}, w);
      n = 0;
      w = 32'h1;
      while (w[0] !== 1'b0 && n < 64) begin
         ahb(1'b0, TCB_AHB_STATUS, 32'h0, w);
         n++;
      end
      chk({15'h0, w[0]}, 16'h0000);
      ahb(1'b0, TCB_AHB_RDATA, 32'h0, w);
      r = cmd[2] ? {8'h00, w[7:0]} : w[15:0];
   endtask : dev
   task automatic t_reset();
      chk({14'h0, hreadyout, hresp}, 16'h0002);
      chk({14'h0, count_bottom, overflow_flag}, 16'h0002);
      dev(RD, TCB_LOC_CNT_LO, 16'h0, q);
      chk(q, 16'h0000);
   endtask : t_reset
   task automatic t_word();
      logic [3:0]  locs[3] = '{TCB_LOC_CNT_LO, TCB_LOC_CMPA_LO, TCB_LOC_CMPB_LO};
      logic [15:0] vals[3] = '{16'h01FF, 16'hA55A, 16'h1234};
      logic [31:0] w;
      foreach (locs[i]) dev(WR, locs[i], vals[i], q);
      foreach (locs[i]) begin
         dev(RD, locs[i], 16'h0, q);
         chk(q, vals[i]);
      end
      // holder still has 01 from the count read; compare reads left it alone
      dev(KW, TCB_LOC_CMPA_LO, 16'h0077, q);
      dev(RD, TCB_LOC_CMPA_LO, 16'h0, q);
      chk(q, 16'h0177);
      dev(BW, TCB_LOC_CNT_HI, 16'h003C, q);
      dev(BR, TCB_LOC_CMPB_HI, 16'h0, q);
      chk(q, 16'h0012);
      dev(BR, TCB_LOC_CNT_HI, 16'h0, q);
      chk(q, 16'h003C);
      dev(BR, TCB_LOC_CAPT_HI, 16'h0, q);
      chk(q, 16'h003C);
      dev(RD, TCB_LOC_CNT_LO, 16'h0, q);
      chk(q, 16'h01FF);
      dev(BR, 4'hC, 16'h0, q);
      chk(q, 16'h0000);
      ahb(1'b1, 8'h40, 32'hFFFF_FFFF, w);
      ahb(1'b0, 8'h40, 32'h0, w);
      chk(w[15:0], 16'h0000);
   endtask : t_word
   task automatic t_src();
      int          dv[7] = '{1, 8, 64, 256, 1024, 16, 16};
      logic [15:0] a;
      for (int cs = 1; cs < 8; cs++) begin
         dev(WR, TCB_LOC_CNT_LO, 16'h0, q);
         dev(BW, TCB_LOC_CTRL_B, 16'(cs), q);
         dev(BR, TCB_LOC_CTRL_B, 16'h0, q);
         chk(q, 16'(cs));
         repeat (2048) @(posedge clk);
         dev(BW, TCB_LOC_CTRL_B, 16'h0, q);
         dev(RD, TCB_LOC_CNT_LO, 16'h0, a);
         dev(RD, TCB_LOC_CNT_LO, 16'h0, q);
         chk(q, a);
         chk_in(a, 16'(2047 / dv[cs - 1]), 16'(2112 / dv[cs - 1] + 1));
      end
   endtask : t_src
   task automatic t_mode();
      logic [3:0]  md[5] = '{4'h4, 4'h5, 4'h1, 4'h7, 4'h0};
      logic [15:0] tp[5] = '{16'h0010, TCB_TOP8, TCB_TOP8, TCB_TOP10, TCB_MAX};
      logic [15:0] st[5] = '{16'h0005, 16'h0005, 16'h0005, 16'h0005, 16'hFFF0};
      logic        ov[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
      int          t0;
      int          b0;
      dev(WR, TCB_LOC_CMPA_LO, 16'h0010, q);
      foreach (md[i]) begin
         dev(WR, TCB_LOC_CNT_LO, st[i], q);
         dev(BW, TCB_LOC_FLAGS, 16'h0001, q);
         dev(BW, TCB_LOC_CTRL_A, {14'h0, md[i][1:0]}, q);
         t0 = top_n;
         b0 = bot_n;
         dev(BW, TCB_LOC_CTRL_B, {11'h0, md[i][3:2], 3'h1}, q);
         repeat (2100) @(posedge clk);
         dev(BW, TCB_LOC_CTRL_B, 16'h0, q);
         dev(RD, TCB_LOC_CNT_LO, 16'h0, q);
         chk_in(q, 16'h0000, tp[i]);
         chk({14'h0, top_n != t0, bot_n != b0}, 16'h0003);
         chk({15'h0, overflow_flag}, {15'h0, ov[i]});
      end
      dev(BW, TCB_LOC_FLAGS, 16'h0001, q);
      chk({15'h0, overflow_flag}, 16'h0000);
      dev(BW, TCB_LOC_CTRL_A, 16'h0, q);
   endtask : t_mode
   task automatic t_wrun();
      dev(WR, TCB_LOC_CNT_LO, 16'h0, q);
      dev(BW, TCB_LOC_CTRL_B, 16'h0001, q);
      dev(RD, TCB_LOC_CNT_LO, 16'h0, q);
      chk_in(q, 16'h0001, 16'h0040);
      dev(WR, TCB_LOC_CNT_LO, 16'h8000, q);
      dev(BW, TCB_LOC_CTRL_B, 16'h0, q);
      dev(RD, TCB_LOC_CNT_LO, 16'h0, q);
      chk_in(q, 16'h8000, 16'h8040);
   endtask : t_wrun
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_word();
      t_src();
      t_mode();
      t_wrun();
      tally_and_finish();
   end
   initial begin
      #(8 * 60000);
      fails++;
      tally_and_finish();
   end
endmodule : tcb_bench
